//--- emc_controller.sv
// module: external memory bus controller with slave fetch pointer and prefetch queue
`timescale 1ns/100ps
module emc_controller
  import emc_pkg::*;
#(
  parameter bit HAS_ROM = 1'b1
)(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // arithmetic unit side
  input  wire logic          jump_i,          // reload strobe
  input  wire logic [7:0]    abus_i,          // 8-bit internal bus, low then high
  input  wire logic          fetch_ready_i,   // consumer takes a queued byte
  output logic [7:0]         fetch_byte_o,
  output logic               fetch_valid_o,
  input  wire emc_req_type   req_i,
  output logic               req_ready_o,
  output logic               internal_hit_o,  // access bypasses the bus
  output emc_region_type     internal_region_o,
  output logic               data_valid_o,
  output logic [15:0]        rdata_o,
  // internal program memory
  input  wire logic          ext_access_pin_i,
  output logic               rom_read_o,
  output logic [15:0]        rom_addr_o,
  input  wire logic [7:0]    rom_data_i,
  // multiplexed bus pins
  input  wire logic [15:0]   bus_in_i,
  input  wire logic          ready_i,
  output emc_pins_type       pins_o,
  output logic               state_clock_out_o
);
  // ========================================
  // decode
  function automatic emc_region_type region_of(input logic [15:0] a);
    if (a <= SFR_LAST)                            region_of = EMC_SFR;
    else if (a == STACK_PTR_LO || a == STACK_PTR_HI) region_of = EMC_SP;
    else if (a <= INTERNAL_LAST)                  region_of = EMC_REGFILE;
    else                                          region_of = EMC_EXT;
  endfunction

  // internal program memory window only with part rom and access pin high
  function automatic logic rom_hit(input logic [15:0] a, input logic ea);
    rom_hit = HAS_ROM && ea && (a >= ROM_FIRST) && (a <= ROM_LAST);
  endfunction

  typedef enum {ST_IDLE, ST_RELOAD_HI, ST_RELOAD_WAIT, ST_ADDR, ST_STROBE,
                ST_WAIT, ST_END} emc_fsm_type;

  typedef struct packed {
    emc_fsm_type  fsm;
    logic [15:0]  ptr;
    logic [7:0]   reload_lo;
    logic [2:0]   reload_cnt;
    logic [QUEUE_DEPTH-1:0][7:0] q;
    logic [1:0]   q_cnt;
    logic         is_fetch;
    logic         is_write;
    logic         is_word;
    logic [15:0]  addr;
    logic [15:0]  wdata;
    logic [15:0]  rdata;
    logic         dvalid;
    logic         ea_meta;
    logic         ea_sync;
    emc_pins_type pins;
  } emc_st_type;

  emc_st_type s_reg;
  emc_st_type s_next;

  logic tick;
  logic rdy;

  emc_state_clock u_clk (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .ready_i          (ready_i),
    .state_tick_o     (tick),
    .ready_sync_o     (rdy),
    .state_clock_out_o(state_clock_out_o)
  );

  logic data_ext;
  logic pop;
  logic fetch_rom;
  assign data_ext  = req_i.valid && (region_of(req_i.addr) == EMC_EXT);
  assign pop       = fetch_valid_o && fetch_ready_i;
  assign fetch_rom = rom_hit(s_reg.ptr, s_reg.ea_sync);

  // ========================================
  // next state
  always_comb begin
    s_next         = s_reg;
    s_next.dvalid  = 1'b0;
    s_next.ea_meta = ext_access_pin_i;
    s_next.ea_sync = s_reg.ea_meta;
    // consumer pops head; queue shifts down
    if (pop) begin
      s_next.q     = {8'h00, s_reg.q[QUEUE_DEPTH-1:1]};
      s_next.q_cnt = s_reg.q_cnt - 2'h1;
    end
    case (s_reg.fsm)
      ST_IDLE: begin
        if (jump_i) begin
          s_next.reload_lo = abus_i;
          s_next.q_cnt     = 2'h0;                       // flush stale stream
          s_next.fsm       = ST_RELOAD_HI;
        end else if (data_ext) begin
          s_next.is_fetch = 1'b0;
          s_next.is_write = req_i.write;
          s_next.is_word  = req_i.word;
          s_next.addr     = req_i.addr;
          s_next.wdata    = req_i.wdata;
          s_next.fsm      = ST_ADDR;
        end else if (s_next.q_cnt < 2'(QUEUE_DEPTH)) begin
          if (fetch_rom) begin
            s_next.q[s_next.q_cnt] = rom_data_i;
            s_next.q_cnt           = s_next.q_cnt + 2'h1;
            s_next.ptr             = s_reg.ptr + 16'h0001;
          end else begin
            s_next.is_fetch = 1'b1;
            s_next.is_write = 1'b0;
            s_next.is_word  = 1'b0;
            s_next.addr     = s_reg.ptr;
            s_next.fsm      = ST_ADDR;
          end
        end
      end
      ST_RELOAD_HI: begin
        s_next.ptr        = {abus_i, s_reg.reload_lo};
        s_next.q_cnt      = 2'h0;
        s_next.reload_cnt = 3'h0;
        s_next.fsm        = ST_RELOAD_WAIT;
      end
      ST_RELOAD_WAIT: begin
        // stall fetching three state times so reload plus a first byte from internal program memory spans four
        if (tick) begin
          s_next.reload_cnt = s_reg.reload_cnt + 3'h1;
          if (s_reg.reload_cnt == 3'(RELOAD_STATES - 2)) begin
            s_next.fsm = ST_IDLE;
          end
        end
      end
      ST_ADDR: begin
        // strobe high, address and high select on the bus
        if (tick) begin
          s_next.pins.addr_strobe        = 1'b1;
          s_next.pins.bus_out            = s_reg.addr;
          s_next.pins.bus_oe             = 1'b1;
          // lane encoding: odd byte or word drives high select low
          s_next.pins.high_byte_select_n = !(s_reg.addr[0] || s_reg.is_word);
          s_next.pins.fetch_type_flag    = s_reg.is_fetch && !s_reg.is_write;
          s_next.fsm                     = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tick) begin
          s_next.pins.addr_strobe     = 1'b0;
          s_next.pins.fetch_type_flag = 1'b0;
          if (s_reg.is_write) begin
            s_next.pins.write_n = 1'b0;
            s_next.pins.bus_out = s_reg.addr[0] ? {s_reg.wdata[7:0], 8'h00} : s_reg.wdata;
          end else begin
            s_next.pins.read_n = 1'b0;
            s_next.pins.bus_oe = 1'b0;
          end
          s_next.fsm = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // ready checked once per state time: waits are whole periods
        if (tick && rdy) begin
          s_next.fsm = ST_END;
        end
      end
      ST_END: begin
        if (tick) begin
          s_next.pins.read_n  = 1'b1;
          s_next.pins.write_n = 1'b1;
          s_next.pins.bus_oe  = 1'b0;
          s_next.pins.high_byte_select_n = 1'b1;
          s_next.fsm = ST_IDLE;
          if (!s_reg.is_write) begin
            if (s_reg.is_fetch) begin
              // capture at read strobe rise; odd byte rides high lane
              s_next.q[s_next.q_cnt] = s_reg.addr[0] ? bus_in_i[15:8] : bus_in_i[7:0];
              s_next.q_cnt           = s_next.q_cnt + 2'h1;
              s_next.ptr             = s_reg.ptr + 16'h0001;
            end else begin
              s_next.rdata  = (s_reg.addr[0] && !s_reg.is_word) ? {8'h00, bus_in_i[15:8]}
                                                                 : bus_in_i;
              s_next.dvalid = 1'b1;
            end
          end
        end
      end
      default: s_next.fsm = ST_IDLE;
    endcase
    if (jump_i && s_reg.fsm != ST_IDLE && s_reg.fsm != ST_RELOAD_HI) begin
      s_next.reload_lo = abus_i;   // low half kept only; reload is refused outside idle
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg                         <= '0;
      s_reg.fsm                     <= ST_IDLE;
      s_reg.ptr                     <= PTR_RESET;
      s_reg.pins.read_n             <= 1'b1;
      s_reg.pins.write_n            <= 1'b1;
      s_reg.pins.high_byte_select_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ========================================
  // outputs
  assign fetch_byte_o      = s_reg.q[0];
  assign fetch_valid_o     = (s_reg.q_cnt != 2'h0);
  assign req_ready_o       = (s_reg.fsm == ST_IDLE) && !jump_i;
  assign internal_hit_o    = req_i.valid && !data_ext;
  assign internal_region_o = region_of(req_i.addr);
  assign data_valid_o      = s_reg.dvalid;
  assign rdata_o           = s_reg.rdata;
  assign rom_read_o        = (s_reg.fsm == ST_IDLE) && fetch_rom;
  assign rom_addr_o        = s_reg.ptr;
  assign pins_o            = s_reg.pins;
endmodule // emc_controller

//--- emc_pkg.sv
// package: constants and carrier types of the external memory bus controller
// Contract
// - slave fetch pointer increments after every instruction byte fetch
// - jump or call reloads pointer from 8-bit internal bus; fetching stalls meanwhile
// - three-byte prefetch queue, invisible except under wait states
// - pointer reload plus first new byte takes four state times (internal program memory only; external adds a bus cycle)
// - 16-bit address and data time-multiplexed on one sixteen-line bus
// - byte lanes: even byte, odd byte with high select, or full word
// - read: strobe high with address, strobe low, address off, read low
// - ready sampled once per state clock; waits are whole state periods
// - read data captured at rising edge of read strobe
// - fetch type flag high for fetches, low for data and writes
// - write sequences as read, then drives data, rising write latches
// - register file and special function space bypass this controller
// - 00h-17h special functions, 18h-19h stack pointer, rest storage only
// - special function addresses differ in function by read or write
// - one state time equals three oscillator periods
// - internal program memory only if present, access pin high, 2000h-3fffh
package emc_pkg;
  // ========================================
  // timing
  localparam int          OSC_PER_STATE     = 3;    // clocks per state time
  localparam int          RELOAD_STATES     = 4;    // reload plus first fetch
  localparam int          QUEUE_DEPTH       = 3;
  // ========================================
  // address map
  localparam logic [15:0] SFR_LAST          = 16'h0017;
  localparam logic [15:0] STACK_PTR_LO      = 16'h0018;
  localparam logic [15:0] STACK_PTR_HI      = 16'h0019;
  localparam logic [15:0] INTERNAL_LAST     = 16'h00ff;
  localparam logic [15:0] ROM_FIRST         = 16'h2000;
  localparam logic [15:0] ROM_LAST          = 16'h3fff;
  localparam logic [15:0] PTR_RESET         = 16'h2080;

  // internal region decode result
  typedef enum logic [1:0] {EMC_EXT, EMC_SFR, EMC_SP, EMC_REGFILE} emc_region_type;

  // data access request from the arithmetic unit
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } emc_req_type;

  // pin-side outputs of the multiplexed bus
  typedef struct packed {
    logic [15:0] bus_out;
    logic        bus_oe;
    logic        addr_strobe;
    logic        high_byte_select_n;
    logic        read_n;
    logic        write_n;
    logic        fetch_type_flag;
  } emc_pins_type;
endpackage

//--- emc_state_clock.sv
// module: state-time phase generator with ready synchroniser
`timescale 1ns/100ps
module emc_state_clock
  import emc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ready_i,
  output logic      state_tick_o,
  output logic      ready_sync_o,
  output logic      state_clock_out_o
);
  typedef struct packed {
    logic [1:0] phase;
    logic       rdy_meta;
    logic       rdy_sync;
    logic       clk_out;
  } emc_sc_type;

  emc_sc_type s_reg;
  emc_sc_type s_next;

  // one state time is three oscillator periods
  always_comb begin
    s_next          = s_reg;
    s_next.phase    = (s_reg.phase == 2'(OSC_PER_STATE - 1)) ? 2'h0 : s_reg.phase + 2'h1;
    s_next.rdy_meta = ready_i;
    s_next.rdy_sync = s_reg.rdy_meta;
    s_next.clk_out  = (s_next.phase == 2'h0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign state_tick_o      = (s_reg.phase == 2'(OSC_PER_STATE - 1));
  assign ready_sync_o      = s_reg.rdy_sync;
  assign state_clock_out_o = s_reg.clk_out;
endmodule // emc_state_clock

//--- emc_checker.sv
// checker: port assertions of the memory bus controller
`timescale 1ns/100ps
module emc_checker
  import emc_pkg::*;
(
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire emc_req_type    req_i,
  input wire logic           internal_hit_o,
  input wire emc_region_type internal_region_o,
  input wire emc_pins_type   pins_o,
  input wire logic           state_clock_out_o
);
  // ========================================
  // helpers
  logic [15:0] low_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // strobe low time, cleared while both strobes idle
  always_ff @(posedge clk_i) begin
    if (rst_i || (pins_o.read_n && pins_o.write_n)) low_cnt <= 16'h0000;
    else low_cnt <= low_cnt + 16'h0001;
  end
  // ========================================
  // assertions
  chk_state_period: assert property (
    state_clock_out_o |=> !state_clock_out_o ##1 !state_clock_out_o ##1 state_clock_out_o)
    else $error("bad state clock");
  chk_strobe_addr: assert property (
    pins_o.addr_strobe |-> pins_o.bus_oe && pins_o.read_n && pins_o.write_n)
    else $error("strobe without address");
  chk_strobe_fall: assert property (
    $fell(pins_o.addr_strobe) |-> (pins_o.read_n != pins_o.write_n)
      && (pins_o.bus_oe == !pins_o.write_n))
    else $error("bad strobe fall");
  chk_write_data: assert property (
    !pins_o.write_n |-> pins_o.bus_oe && !pins_o.addr_strobe)
    else $error("write data not driven");
  chk_write_flag: assert property (
    !pins_o.write_n |-> !pins_o.fetch_type_flag)
    else $error("fetch flag in write");
  chk_wait_whole: assert property (
    $rose(pins_o.read_n && pins_o.write_n) |-> low_cnt % 16'h0003 == 16'h0000)
    else $error("strobe time not whole states");
  chk_bypass_hit: assert property (
    req_i.valid |-> internal_hit_o == (req_i.addr <= INTERNAL_LAST))
    else $error("bad bypass decode");
  chk_region_map: assert property (
    req_i.valid |-> internal_region_o == (req_i.addr <= SFR_LAST ? EMC_SFR
      : req_i.addr <= STACK_PTR_HI ? EMC_SP
      : req_i.addr <= INTERNAL_LAST ? EMC_REGFILE : EMC_EXT))
    else $error("bad region decode");
endmodule // emc_checker
bind emc_controller emc_checker emc_checker_fetch_type_flag (.clk_i, .rst_i, .req_i, .internal_hit_o,
  .internal_region_o, .pins_o, .state_clock_out_o);

//--- emc_mem_model.sv
// model: external memory and address latch on the multiplexed bus
`timescale 1ns/100ps
module emc_mem_model
  import emc_pkg::*;
(
  input  wire logic         clk_i,
  input  wire emc_pins_type pins_i,
  input  wire logic         slow_i,
  output logic [15:0]       bus_in_o,
  output logic              ready_o,
  output int                fetch_cnt_o
);
  logic [7:0]  mem [65536];
  logic [15:0] la, wd;
  logic        lhbs_n, linst, pwr_n, plow;
  int          wt;
  // pattern fill so each byte within a 256-byte page is distinct
  initial begin
    for (int a = 0; a < 65536; a++) mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
    {pwr_n, plow, ready_o} = 3'b101;
    {wt, fetch_cnt_o} = '0;
    bus_in_o = 16'h0000;
  end
  // latch follows the bus while the strobe is high; banks decode on write rise
  always @(posedge clk_i) begin
    pwr_n <= pins_i.write_n;
    plow <= !(pins_i.read_n && pins_i.write_n);
    if (pins_i.addr_strobe) begin
      la <= pins_i.bus_out;
      lhbs_n <= pins_i.high_byte_select_n;
      linst <= pins_i.fetch_type_flag;
    end
    if (!pins_i.write_n) wd <= pins_i.bus_out;
    if (pins_i.write_n && !pwr_n) begin
      if (!la[0]) mem[la] <= wd[7:0];
      if (!lhbs_n) mem[la | 16'h0001] <= wd[15:8];
    end
    // data stands while read is low; a released bus inverts every clock, so stale data shows only on alternate clocks
    if (!pins_i.read_n) bus_in_o <= {mem[la | 16'h0001], mem[la & 16'hfffe]};
    else bus_in_o <= ~bus_in_o;
    if (!pins_i.read_n && !plow && linst) fetch_cnt_o <= fetch_cnt_o + 1;
    // not ready from the address phase on, so the first ready sample already waits;
    // the hold stays far below the ceiling and ends at a random moment
    if (pins_i.addr_strobe && slow_i) begin
      wt      <= $urandom_range(20, 3);
      ready_o <= 1'b0;
    end else begin
      if (wt > 0) wt <= wt - 1;
      ready_o <= (wt <= 1);
    end
  end
endmodule // emc_mem_model

//--- tb_top.sv
// testbench: controller against a memory model with a behavioural reference
`timescale 1ns/100ps
module tb_top
  import emc_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, jump_i = 1'b0, fetch_ready_i = 1'b0;
  logic ext_access_pin_i = 1'b0, slow = 1'b0;
  logic [7:0] abus_i = 8'h00, fetch_byte_o, rom_data_i;
  emc_req_type req_i = '0;
  logic fetch_valid_o, req_ready_o, internal_hit_o, data_valid_o, rom_read_o;
  logic ready_i, state_clock_out_o;
  logic [15:0] rdata_o, rom_addr_o, bus_in_i;
  emc_region_type internal_region_o;
  emc_pins_type pins_o;
  int err_count = 0, samples_checked = 0, fetch_cnt;
  logic [7:0] tm [int];
  logic [15:0] ia [6] = '{16'h0000, 16'h0017, 16'h0018, 16'h0019, 16'h001a, 16'h00ff};
  // ========================================
  // clock, design, memory
  always #2 clk_i = ~clk_i;
  assign rom_data_i = 8'(rom_addr_o) ^ 8'(rom_addr_o >> 8) ^ 8'h5a;
  emc_controller #(.HAS_ROM(1'b1)) emc_controller_fetch_type_flag (.clk_i, .rst_i, .jump_i, .abus_i,
    .fetch_ready_i, .fetch_byte_o, .fetch_valid_o, .req_i, .req_ready_o, .internal_hit_o,
    .internal_region_o, .data_valid_o, .rdata_o, .ext_access_pin_i, .rom_read_o,
    .rom_addr_o, .rom_data_i, .bus_in_i, .ready_i, .pins_o, .state_clock_out_o);
  emc_mem_model emc_mem_model_fetch_type_flag (.clk_i, .pins_i(pins_o), .slow_i(slow),
    .bus_in_o(bus_in_i), .ready_o(ready_i), .fetch_cnt_o(fetch_cnt));
  // ========================================
  // reference and tasks
  function automatic logic [7:0] ref_byte(int a);
    return tm.exists(a) ? tm[a] : 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_idle();
    @(negedge clk_i);
    for (int n = 0; req_ready_o !== 1'b1 && n < 400; n++) @(negedge clk_i);
  endtask
  // head is read before the pop edge, one pop per call
  task automatic pop(output logic [7:0] b);
    @(negedge clk_i);
    for (int n = 0; fetch_valid_o !== 1'b1 && n < 400; n++) @(negedge clk_i);
    b = fetch_byte_o;
    @(posedge clk_i) fetch_ready_i <= 1'b1;
    @(posedge clk_i) fetch_ready_i <= 1'b0;
  endtask
  // request held until taken, then read data picked up at its pulse
  task automatic access(logic wr, wd, logic [15:0] a, d, output logic [15:0] q);
    @(posedge clk_i) req_i <= '{1'b1, wr, wd, a, d};
    wait_idle();
    @(posedge clk_i) req_i.valid <= 1'b0;
    @(negedge clk_i);
    for (int n = 0; !wr && data_valid_o !== 1'b1 && n < 400; n++) @(negedge clk_i);
    q = rdata_o;
  endtask
  // reload is only taken in idle: idle at two edges in a row means a full queue when fetching over the external bus
  task automatic jump(logic [15:0] t, output int c);
    int s = 0;
    for (int n = 0; s < 2 && n < 2000; n++) begin
      @(negedge clk_i);
      s = (req_ready_o === 1'b1) ? s + 1 : 0;
    end
    @(posedge clk_i) {jump_i, abus_i} <= {1'b1, t[7:0]};
    @(posedge clk_i) {jump_i, abus_i} <= {1'b0, t[15:8]};
    @(posedge clk_i) abus_i <= 8'($urandom);
    for (c = 2; fetch_valid_o !== 1'b1 && c < 400; c++) @(negedge clk_i);
  endtask
  // ========================================
  // scenarios
  initial begin
    logic [7:0] b;
    logic [15:0] a, d, q, t;
    logic w;
    int c, f;
    void'($urandom(15811));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (150) @(posedge clk_i);
    check(fetch_cnt, QUEUE_DEPTH);
    for (int k = 0; k < 6; k++) begin
      pop(b);
      check(b, ref_byte(16'h2080 + k));
    end
    // external jump under stretched bus cycles
    slow <= 1'b1;
    t = 16'h4000 + 16'($urandom % 32'hb000);
    jump(t, c);
    for (int k = 0; k < 4; k++) begin
      pop(b);
      check(b, ref_byte(t + k));
    end
    // byte and word traffic, lanes checked through word read-back
    for (int k = 0; k < 12; k++) begin
      slow <= 1'($urandom);
      a = 16'h0100 + 16'($urandom % 32'h1e00);
      d = 16'($urandom);
      w = (k % 3 == 2);
      if (w) a[0] = 1'b0;
      else d[15:8] = d[7:0];
      access(1'b1, w, a, d, q);
      tm[a] = d[7:0];
      if (w) tm[a + 1] = d[15:8];
      access(1'b0, 1'b1, a & 16'hfffe, 16'h0000, q);
      check(q, {ref_byte(a | 16'h0001), ref_byte(a & 16'hfffe)});
      access(1'b0, 1'b0, a, 16'h0000, q);
      check(q[7:0], ref_byte(a));
    end
    // internal space decodes and bypasses the bus
    foreach (ia[i]) begin
      @(posedge clk_i) req_i <= '{1'b1, 1'(i), 1'b0, ia[i], 16'h0000};
      @(negedge clk_i);
      check(internal_hit_o, 1'b1);
      check(internal_region_o, ia[i] <= SFR_LAST ? EMC_SFR
        : ia[i] <= STACK_PTR_HI ? EMC_SP : EMC_REGFILE);
      @(posedge clk_i) req_i.valid <= 1'b0;
    end
    // internal program memory: quick reload, no external fetch
    ext_access_pin_i <= 1'b1;
    slow <= 1'b0;
    t = ROM_FIRST + 16'($urandom % 32'h1ff0);
    jump(t, c);
    check(c <= RELOAD_STATES * OSC_PER_STATE + OSC_PER_STATE, 1'b1);
    f = fetch_cnt;
    for (int k = 0; k < 4; k++) begin
      pop(b);
      check(b, ref_byte(t + k));
    end
    check(fetch_cnt, f);
    repeat (3) @(negedge clk_i);
    check(rom_addr_o, t + 16'h0007);
    check(rom_read_o, 1'b1);
    end_of_test();
  end
  // hang guard, many times the expected run
  initial begin
    #(60000 * 4);
    err_count++;
    end_of_test();
  end
endmodule // tb_top
